// *** bench/tb_tmos_timer.sv ***
// Self-checking bench of the one-shot and monostable timer.
`timescale 1ns/1ps
`default_nettype none
module tb_tmos_timer;
    import tmos_pkg::*;
    logic clk, rst_n, run_set, run_clr, pin_req, pin, run, pm, drv;
    logic [4:0] mode;
    logic [7:0] per, cnt;
    int error_cnt, checks, starts, s0;
    logic [4:0] modes [6] = '{5'h09, 5'h0a, 5'h0b, 5'h11, 5'h12, 5'h13};

    tmos_timer uut (.i_ref_clk(clk), .i_arst_n(rst_n), .i_mode(mode), .i_period_value(per),
        .i_pulse_width_value(8'h03), .i_run_set(run_set), .i_run_clr(run_clr),
        .i_external_trigger_input(pin), .o_run(run), .o_timer_count(cnt),
        .o_period_match(pm), .o_pwm_drive(drv));
    tmos_far_end far (.i_ref_clk(clk), .i_pin_req(pin_req), .i_pwm_drive(drv),
        .o_pin(pin), .o_starts(starts));

    // Clock of 100 ns.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : tick

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_cnt(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_cnt

    // Bounded wait on drive (0), period match (1) or a running count (2).
    task automatic wait_sig(input int which, input logic v);
        int i;
        logic s;
        s = 1'b0;
        for (i = 0; i < 60; i++) begin
            s = (which == 0) ? drv : (which == 1) ? pm : (cnt !== 8'h00);
            if (s === v) break;
            tick(1);
        end
        if (s !== v) begin
            error_cnt++;
            conclude();
        end
    endtask : wait_sig

    task automatic pulse(input logic set);
        if (set) run_set = 1'b1;
        else run_clr = 1'b1;
        tick(1);
        if (set) run_set = 1'b0;
        else run_clr = 1'b0;
    endtask : pulse

    // Monostable: later edges while counting change nothing, match leaves drive off.
    task automatic t_mono();
        mode = TMOS_M_MS_BOTH;
        per = 8'h10;
        pin_req = 1'b0;
        tick(4);
        pulse(1'b1);
        pin_req = 1'b1;
        wait_sig(0, 1'b1);
        wait_sig(0, 1'b0);
        pin_req = 1'b0;
        tick(6);
        cmp_bit(drv, 1'b0);
        cmp_cnt(cnt, 8'h0a);
        wait_sig(1, 1'b1);
        tick(2);
        cmp_bit(drv, 1'b0);
        cmp_cnt(cnt, 8'h10);
        pulse(1'b0);
        per = 8'h05;
        tick(2);
    endtask : t_mono

    // Every edge mode: no start before the edge, start on it, end at period match.
    task automatic t_edge_modes();
        logic lv;
        foreach (modes[k]) begin
            mode = modes[k];
            lv = (mode == 5'h0a || mode == 5'h12 || mode == 5'h0b);
            pin_req = lv;
            tick(4);
            pulse(1'b1);
            tick(4);
            cmp_cnt(cnt, 8'h00);
            pin_req = !lv;
            wait_sig(0, 1'b1);
            cmp_bit(run, 1'b1);
            wait_sig(1, 1'b1);
            tick(1);
            cmp_bit(run, mode[4]);
            cmp_cnt(cnt, mode[4] ? per : 8'h00);
            cmp_bit(drv, 1'b0);
            pulse(1'b0);
            tick(2);
            cmp_cnt(cnt, 8'h00);
        end
    endtask : t_edge_modes

    // Software halt in edge one-shot needs a fresh edge.
    task automatic t_halt();
        mode = TMOS_M_OS_RISE;
        pin_req = 1'b0;
        tick(4);
        pulse(1'b1);
        pin_req = 1'b1;
        wait_sig(2, 1'b1);
        pulse(1'b0);
        pulse(1'b1);
        tick(6);
        cmp_cnt(cnt, 8'h00);
        pin_req = 1'b0;
        tick(4);
        pin_req = 1'b1;
        wait_sig(2, 1'b1);
        wait_sig(1, 1'b1);
        pin_req = 1'b0;
    endtask : t_halt

    // Hardware-limit edge one-shot: restart edge, auto resume, off edges ignored.
    task automatic t_hl();
        mode = TMOS_M_HL_RISE;
        per = 8'h20;
        tick(4);
        pulse(1'b1);
        pin_req = 1'b1;
        wait_sig(0, 1'b1);
        wait_sig(0, 1'b0);
        pin_req = 1'b0;
        s0 = starts;
        tick(2);
        pin_req = 1'b1;
        wait_sig(0, 1'b1);
        cmp_cnt(cnt, 8'h00);
        tick(4);
        cmp_bit(cnt !== 8'h00, 1'b1);
        cmp_cnt(8'(starts - s0), 8'h01);
        wait_sig(1, 1'b1);
        tick(1);
        cmp_bit(run, 1'b0);
        pin_req = 1'b0;
        tick(4);
        pin_req = 1'b1;
        tick(6);
        cmp_cnt(cnt, 8'h00);
        cmp_bit(drv, 1'b0);
        per = 8'h05;
        pin_req = 1'b0;
    endtask : t_hl

    // Level reset with edge start, then level-limit start by run or by level.
    task automatic t_levels();
        mode = TMOS_M_LR_LOW;
        pulse(1'b1);
        tick(8);
        cmp_cnt(cnt, 8'h00);
        pin_req = 1'b1;
        wait_sig(0, 1'b1);
        wait_sig(1, 1'b1);
        tick(1);
        cmp_bit(drv, 1'b0);
        pulse(1'b1);
        tick(8);
        cmp_cnt(cnt, 8'h00);
        pulse(1'b0);
        mode = TMOS_M_LL_LOW;
        tick(2);
        pulse(1'b1);
        wait_sig(0, 1'b1);
        pin_req = 1'b0;
        tick(5);
        cmp_cnt(cnt, 8'h00);
        pin_req = 1'b1;
        wait_sig(1, 1'b1);
        tick(4);
        cmp_cnt(cnt, 8'h00);
        pin_req = 1'b0;
        tick(4);
        pulse(1'b1);
        tick(6);
        cmp_cnt(cnt, 8'h00);
        cmp_bit(drv, 1'b0);
        pin_req = 1'b1;
        wait_sig(0, 1'b1);
        pulse(1'b0);
    endtask : t_levels

    // Main sequence.
    initial begin
        error_cnt = 0;
        checks = 0;
        rst_n = 1'b0;
        run_set = 1'b0;
        run_clr = 1'b0;
        pin_req = 1'b0;
        mode = TMOS_M_OS_RISE;
        per = 8'h05;
        tick(10);
        rst_n = 1'b1;
        cmp_bit(run, 1'b0);
        cmp_cnt(cnt, 8'h00);
        t_edge_modes();
        t_mono();
        t_halt();
        t_hl();
        t_levels();
        conclude();
    end
endmodule : tb_tmos_timer
`default_nettype wire

// *** bench/tmos_far_end.sv ***
// Far-end model: trigger source driving the pin and watcher of drive starts.
`timescale 1ns/1ps
`default_nettype none
module tmos_far_end (
    // Clock, request and watched drive.
    input wire logic i_ref_clk,
    input wire logic i_pin_req,
    input wire logic i_pwm_drive,
    // Pin and observations.
    output logic o_pin,
    output int o_starts
);
    logic drive_q;
    // The pin follows the request with a small skew, like a real source.
    always @(i_pin_req) o_pin <= #3 i_pin_req;
    // Each rising edge of the drive counts as one started pulse.
    always @(posedge i_ref_clk) begin
        drive_q <= i_pwm_drive;
        if (i_pwm_drive === 1'b1 && drive_q === 1'b0) o_starts <= o_starts + 1;
    end
    // Start values of the model.
    initial begin
        o_pin = 1'b0;
        o_starts = 0;
        drive_q = 1'b0;
    end
endmodule : tmos_far_end
`default_nettype wire

// *** logic/tmos_pkg.sv ***
// Package with mode codes, widths and reset values for the one-shot timer block.
// Overview of operation
// - Edge one-shot: qualifying edge after run starts count; period match clears run.
// - Edge one-shot: after software halt, a fresh edge is needed to resume.
// - Edge one-shot: start edge activates drive; width match ends it; stays off.
// - Edge limit one-shot: first edge starts, later edges reset the count.
// - Edge limit one-shot: after an edge reset, counting resumes two clocks later.
// - Edge limit one-shot: period match resets and clears run; edges ignored when off.
// - Edge limit one-shot: start and reset edges activate drive; width match ends it.
// - Level reset one-shot: reset level holds count; transition to active starts it.
// - Level reset one-shot: period match clears run; new edge needed after rerun.
// - Level reset one-shot: start edge activates drive; no reactivation at period match.
// - Monostable: edge after run starts count; counting stops at period match.
// - Monostable: start edge activates drive; later edges while counting change nothing.
// - Level limit one-shot: reset level holds count; count needs run and inactive level.
// - Level limit one-shot: after run clears, stay reset until run and level both allow.
// - Level limit one-shot: drive activates at whichever event actually starts the timer.
// - Run bit clear holds all counters and mode state in reset.
package tmos_pkg;
    localparam int TMOS_CNT_W = 8;
    localparam logic [4:0] TMOS_M_OS_RISE = 5'h09;
    localparam logic [4:0] TMOS_M_OS_FALL = 5'h0a;
    localparam logic [4:0] TMOS_M_OS_BOTH = 5'h0b;
    localparam logic [4:0] TMOS_M_HL_RISE = 5'h0c;
    localparam logic [4:0] TMOS_M_HL_FALL = 5'h0d;
    localparam logic [4:0] TMOS_M_LR_LOW = 5'h0e;
    localparam logic [4:0] TMOS_M_LR_HIGH = 5'h0f;
    localparam logic [4:0] TMOS_M_MS_RISE = 5'h11;
    localparam logic [4:0] TMOS_M_MS_FALL = 5'h12;
    localparam logic [4:0] TMOS_M_MS_BOTH = 5'h13;
    localparam logic [4:0] TMOS_M_LL_LOW = 5'h16;
    localparam logic [4:0] TMOS_M_LL_HIGH = 5'h17;
    // Clocks between an edge reset and the restart of counting.
    localparam int TMOS_RESTART_CLKS = 2;
    localparam logic [1:0] TMOS_HOLD_ZERO = 2'h0;
    localparam logic [1:0] TMOS_HOLD_MAX = 2'(TMOS_RESTART_CLKS - 1);
    // Timer state machine.
    typedef enum logic [1:0] {TMOS_IDLE, TMOS_RUN, TMOS_HOLD, TMOS_DONE} tmos_state_t;
endpackage : tmos_pkg

// *** logic/tmos_sync.sv ***
// Three-stage synchroniser and edge detector for the external trigger input.
`timescale 1ns/1ps
`default_nettype none
module tmos_sync (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // Raw input.
    input wire logic i_async,
    // Synchronised level and edges.
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    logic [2:0] sync_q;
    logic level_q;
    logic level_d;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], i_async};
        end
    end

    // A change is accepted once the last two stages agree, so one-cycle glitches are dropped.
    assign level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_q;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level_d;
        end
    end

    // Level and edges come from the same accepted sample, so an edge never meets a stale level.
    assign o_level = level_d;
    assign o_rise = level_d & ~level_q;
    assign o_fall = ~level_d & level_q;
endmodule : tmos_sync
`default_nettype wire

// *** logic/tmos_timer.sv ***
// Mode control, counter and drive logic of the one-shot and monostable timer.
`timescale 1ns/1ps
`default_nettype none
module tmos_timer #(
    parameter int CNT_W = tmos_pkg::TMOS_CNT_W
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // Configuration.
    input wire logic [4:0] i_mode,
    input wire logic [CNT_W-1:0] i_period_value,
    input wire logic [CNT_W-1:0] i_pulse_width_value,
    // Software run bit: set pulse and clear pulse.
    input wire logic i_run_set,
    input wire logic i_run_clr,
    // External trigger.
    input wire logic i_external_trigger_input,
    // Status and outputs.
    output logic o_run,
    output logic [CNT_W-1:0] o_timer_count,
    output logic o_period_match,
    output logic o_pwm_drive
);
    import tmos_pkg::*;

    // Widths outside this range cannot be served by the counter and compare logic.
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
        $error("tmos_timer: CNT_W out of range");
    end

    tmos_state_t state_q;
    logic run_q;
    logic [CNT_W-1:0] cnt_q;
    logic [1:0] hold_q;
    logic drive_q;
    logic pm_q;
    logic lvl;
    logic rise;
    logic fall;

    tmos_sync u_sync (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_async(i_external_trigger_input),
        .o_level(lvl),
        .o_rise(rise),
        .o_fall(fall)
    );

    // Mode decode helpers.
    function automatic logic is_edge_mode(input logic [4:0] m);
        return (m == TMOS_M_OS_RISE) || (m == TMOS_M_OS_FALL) || (m == TMOS_M_OS_BOTH)
            || (m == TMOS_M_MS_RISE) || (m == TMOS_M_MS_FALL) || (m == TMOS_M_MS_BOTH);
    endfunction : is_edge_mode

    function automatic logic is_hl(input logic [4:0] m);
        return (m == TMOS_M_HL_RISE) || (m == TMOS_M_HL_FALL);
    endfunction : is_hl

    function automatic logic is_lr(input logic [4:0] m);
        return (m == TMOS_M_LR_LOW) || (m == TMOS_M_LR_HIGH);
    endfunction : is_lr

    function automatic logic is_ll(input logic [4:0] m);
        return (m == TMOS_M_LL_LOW) || (m == TMOS_M_LL_HIGH);
    endfunction : is_ll

    function automatic logic is_mono(input logic [4:0] m);
        return (m == TMOS_M_MS_RISE) || (m == TMOS_M_MS_FALL) || (m == TMOS_M_MS_BOTH);
    endfunction : is_mono

    // Qualifying edge for the selected mode.
    logic qual_edge;
    always_comb begin
        unique case (i_mode)
            TMOS_M_OS_RISE, TMOS_M_MS_RISE, TMOS_M_HL_RISE: qual_edge = rise;
            TMOS_M_OS_FALL, TMOS_M_MS_FALL, TMOS_M_HL_FALL: qual_edge = fall;
            TMOS_M_OS_BOTH, TMOS_M_MS_BOTH: qual_edge = rise | fall;
            // Level-reset start edge is the leave of the reset level.
            TMOS_M_LR_LOW: qual_edge = rise;
            TMOS_M_LR_HIGH: qual_edge = fall;
            default: qual_edge = 1'b0;
        endcase
    end

    // Input sits at the reset level in the level modes.
    logic at_reset_lvl;
    assign at_reset_lvl = (i_mode == TMOS_M_LR_LOW || i_mode == TMOS_M_LL_LOW) ? ~lvl : lvl;

    logic match_pr;
    logic match_pw;
    logic clears_run;
    assign match_pr = (cnt_q == i_period_value);
    assign match_pw = (cnt_q == i_pulse_width_value);
    // Period match ends the cycle and clears run except in monostable mode.
    assign clears_run = (state_q == TMOS_RUN) && match_pr && !is_mono(i_mode);

    // Events that start or restart the count.
    logic start_ev;
    logic reset_ev;
    always_comb begin
        start_ev = 1'b0;
        reset_ev = 1'b0;
        if (run_q) begin
            unique case (state_q)
                TMOS_IDLE: begin
                    if (is_ll(i_mode)) begin
                        start_ev = !at_reset_lvl;
                    end else if (is_edge_mode(i_mode) || is_hl(i_mode) || is_lr(i_mode)) begin
                        start_ev = qual_edge;
                    end
                end
                TMOS_RUN, TMOS_HOLD: begin
                    reset_ev = is_hl(i_mode) && qual_edge;
                end
                TMOS_DONE: begin
                    start_ev = 1'b0;
                end
            endcase
        end
    end

    // Run bit: software set, hardware clear at period match; set wins over clear.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run_q <= 1'b0;
        end else if (i_run_set) begin
            run_q <= 1'b1;
        end else if (i_run_clr || clears_run) begin
            run_q <= 1'b0;
        end
    end

    // Mode state machine and counter.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= TMOS_IDLE;
            cnt_q <= '0;
            hold_q <= TMOS_HOLD_ZERO;
        end else if (!run_q) begin
            state_q <= TMOS_IDLE;
            cnt_q <= '0;
            hold_q <= TMOS_HOLD_ZERO;
        end else if ((is_lr(i_mode) || is_ll(i_mode)) && at_reset_lvl) begin
            // level reset hold; level-reset mode then needs an edge
            state_q <= TMOS_IDLE;
            cnt_q <= '0;
        end else if (reset_ev) begin
            state_q <= TMOS_HOLD;
            cnt_q <= '0;
            hold_q <= TMOS_HOLD_ZERO;
        end else begin
            unique case (state_q)
                TMOS_IDLE: begin
                    if (start_ev) begin
                        state_q <= TMOS_RUN;
                    end
                end
                TMOS_RUN: begin
                    if (match_pr) begin
                        cnt_q <= '0;
                        if (is_mono(i_mode)) begin
                            state_q <= TMOS_DONE;
                            cnt_q <= cnt_q;
                        end else begin
                            state_q <= TMOS_IDLE;
                        end
                    end else begin
                        cnt_q <= cnt_q + CNT_W'(1);
                    end
                end
                TMOS_HOLD: begin
                    if (hold_q == TMOS_HOLD_MAX) begin
                        state_q <= TMOS_RUN;
                    end else begin
                        hold_q <= hold_q + 2'h1;
                    end
                end
                TMOS_DONE: begin
                    // Monostable rearms on a new edge after match.
                    if (qual_edge) begin
                        state_q <= TMOS_RUN;
                        cnt_q <= '0;
                    end
                end
            endcase
        end
    end

    // PWM drive: set at start or edge reset, cleared at pulse-width match.
    logic mono_rearm;
    assign mono_rearm = run_q && state_q == TMOS_DONE && qual_edge;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            drive_q <= 1'b0;
        end else if (start_ev || reset_ev || mono_rearm) begin
            drive_q <= 1'b1;
        end else if (state_q == TMOS_RUN && match_pw) begin
            drive_q <= 1'b0;
        end
    end

    // Period match pulse.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pm_q <= 1'b0;
        end else begin
            pm_q <= (state_q == TMOS_RUN) && match_pr && run_q;
        end
    end

    assign o_run = run_q;
    assign o_timer_count = cnt_q;
    assign o_period_match = pm_q;
    assign o_pwm_drive = drive_q;

    property p_off_idle;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        !run_q |=> (state_q == TMOS_IDLE && cnt_q == '0) || run_q;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("counter not reset when off");

    property p_match_clr;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        clears_run && !i_run_set |=> !run_q;
    endproperty
    a_match_clr: assert property (p_match_clr) else $error("run not cleared at match");

    sequence s_hold2;
        state_q == TMOS_HOLD ##1 state_q == TMOS_HOLD;
    endsequence
    property p_restart;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        reset_ev && !i_run_clr |=> s_hold2 ##1 (state_q == TMOS_RUN || !run_q || reset_ev);
    endproperty
    a_restart: assert property (p_restart) else $error("restart delay wrong");

    property p_drive_on;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        start_ev |=> drive_q;
    endproperty
    a_drive_on: assert property (p_drive_on) else $error("drive not set at start");

    property p_lvl_hold;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        run_q && (is_lr(i_mode) || is_ll(i_mode)) && at_reset_lvl |=> cnt_q == '0;
    endproperty
    a_lvl_hold: assert property (p_lvl_hold) else $error("count not held at reset level");

    property p_mono_stop;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        run_q && state_q == TMOS_DONE && !qual_edge |=> $stable(cnt_q);
    endproperty
    a_mono_stop: assert property (p_mono_stop) else $error("count moved after match");

    property p_mono_edge;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        run_q && state_q == TMOS_RUN && is_mono(i_mode) && qual_edge && !drive_q
        |=> !drive_q;
    endproperty
    a_mono_edge: assert property (p_mono_edge) else $error("drive set by later edge");
endmodule : tmos_timer
`default_nettype wire
